// ---- design/sgpd_regs.vh ----
// Constants of the serial grayscale PWM driver: widths, counts and timing.
`ifndef SGPD_REGS_VH
`define SGPD_REGS_VH

`define SGPD_CHANNELS       24
`define SGPD_GS_BITS        12
`define SGPD_SR_BITS        288
`define SGPD_GS_FULL        12'hFFF
`define SGPD_GS_ZERO        12'h000
`define SGPD_CLK_PERIOD_NS  5
`define SGPD_OSC_PERIOD_NS  250
`define SGPD_OSC_DIV        ((`SGPD_OSC_PERIOD_NS) / (`SGPD_CLK_PERIOD_NS))
`define SGPD_TURNON_EDGE    5
`define SGPD_GRP1_NS        24
`define SGPD_GRP2_NS        48
`define SGPD_GRP3_NS        72
`define SGPD_GRP1_CYC       ((`SGPD_GRP1_NS + `SGPD_CLK_PERIOD_NS - 1) / `SGPD_CLK_PERIOD_NS)
`define SGPD_GRP2_CYC       ((`SGPD_GRP2_NS + `SGPD_CLK_PERIOD_NS - 1) / `SGPD_CLK_PERIOD_NS)
`define SGPD_GRP3_CYC       ((`SGPD_GRP3_NS + `SGPD_CLK_PERIOD_NS - 1) / `SGPD_CLK_PERIOD_NS)
`define SGPD_HIST_DEPTH     15
`define SGPD_BUF_DEPTH      2

`endif

// ---- design/sgpd_core.v ----
// Serial grayscale PWM driver: shift register, latch, PWM timing and group stagger.
`timescale 1ns/1ps
`include "sgpd_regs.vh"

module sgpd_core (
	input  wire                        core_clk,
	input  wire                        rst,
	input  wire                        shiftClk,
	input  wire                        serialDataInput,
	input  wire                        latchStrobe,
	input  wire                        outputDisable,
	output wire                        serialDataOutput,
	output wire [`SGPD_CHANNELS-1:0]   sinkChannelOutput
);

	localparam [2:0] ST_BLANK = 3'b001;
	localparam [2:0] ST_WAIT  = 3'b010;
	localparam [2:0] ST_RUN   = 3'b100;

	// The counts are reckoned as integers and cut to their register widths on purpose.
	localparam integer OSC_LAST_I   = `SGPD_OSC_DIV - 1;
	localparam integer TURNON_CNT_I = `SGPD_TURNON_EDGE;
	localparam [5:0]   OSC_LAST     = OSC_LAST_I[5:0];
	localparam [2:0]   TURNON_CNT   = TURNON_CNT_I[2:0];

	integer i;

	// Pin synchronisers; the data pin keeps a third stage so that it is sampled one cycle
	// earlier than the detected clock edge, which keeps the host's hold margin.
	reg        sclkS1_r;
	reg        sclkS2_r;
	reg        sclkS3_r;
	reg        dinS1_r;
	reg        dinS2_r;
	reg        dinS3_r;
	reg        latS1_r;
	reg        latS2_r;
	reg        latS3_r;
	reg        disS1_r;
	reg        disS2_r;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sclkS1_r <= 1'b0;
			sclkS2_r <= 1'b0;
			sclkS3_r <= 1'b0;
			dinS1_r  <= 1'b0;
			dinS2_r  <= 1'b0;
			dinS3_r  <= 1'b0;
			latS1_r  <= 1'b0;
			latS2_r  <= 1'b0;
			latS3_r  <= 1'b0;
			disS1_r  <= 1'b1;
			disS2_r  <= 1'b1;
		end else begin
			sclkS1_r <= shiftClk;
			sclkS2_r <= sclkS1_r;
			sclkS3_r <= sclkS2_r;
			dinS1_r  <= serialDataInput;
			dinS2_r  <= dinS1_r;
			dinS3_r  <= dinS2_r;
			latS1_r  <= latchStrobe;
			latS2_r  <= latS1_r;
			latS3_r  <= latS2_r;
			disS1_r  <= outputDisable;
			disS2_r  <= disS1_r;
		end
	end

	// Edges are found on the second and third stages, so no logic reads a first stage.
	// The shift clock must stand high and low for at least one core cycle each, or an edge is lost.
	wire sclkRise  = sclkS2_r & ~sclkS3_r;
	wire sclkFall  = ~sclkS2_r & sclkS3_r;
	wire latchRise = latS2_r & ~latS3_r;

	// Two-entry buffer between the captured bits and the shift register. The shift
	// register stalls in the cycle of a latch copy, so a bit arriving then waits here.
	reg  [`SGPD_BUF_DEPTH-1:0] bufData_r;
	reg  [1:0]                 bufCount_r;
	wire                       bufInReady  = (bufCount_r != 2'd2);
	wire                       bufInValid  = sclkRise;
	wire                       bufOutValid = (bufCount_r != 2'd0);
	wire                       srReady     = ~latchRise;
	wire                       bufPush     = bufInValid & bufInReady;
	wire                       bufPop      = bufOutValid & srReady;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bufData_r  <= 2'b00;
			bufCount_r <= 2'd0;
		end else begin
			case ({bufPush, bufPop})
				2'b10: begin
					if (bufCount_r == 2'd0) begin
						bufData_r[0] <= dinS3_r;
					end else begin
						bufData_r[1] <= dinS3_r;
					end
					bufCount_r <= bufCount_r + 2'd1;
				end
				2'b01: begin
					bufData_r[0] <= bufData_r[1];
					bufCount_r   <= bufCount_r - 2'd1;
				end
				2'b11: begin
					if (bufCount_r == 2'd1) begin
						bufData_r[0] <= dinS3_r;
					end else begin
						bufData_r[0] <= bufData_r[1];
						bufData_r[1] <= dinS3_r;
					end
				end
				default: begin
					bufCount_r <= bufCount_r;
				end
			endcase
		end
	end

	// Grayscale data holds no reset: its content is undefined until the host loads it.
	reg [`SGPD_SR_BITS-1:0] shiftData_r;
	reg [`SGPD_SR_BITS-1:0] grayscaleData_r;

	always @(posedge core_clk) begin
		if (bufPop) begin
			shiftData_r <= {shiftData_r[`SGPD_SR_BITS-2:0], bufData_r[0]};
		end
		if (latchRise) begin
			grayscaleData_r <= shiftData_r;
		end
	end

	reg serialDataOutput_r;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			serialDataOutput_r <= 1'b0;
		end else if (sclkFall) begin
			serialDataOutput_r <= shiftData_r[`SGPD_SR_BITS-1];
		end
	end

	// Free-running oscillator tick, independent of the shift clock.
	// It is never restarted by the disable pin, so turn-on jitters by up to one tick.
	reg [5:0] oscDiv_r;
	wire      oscTick = (oscDiv_r == OSC_LAST);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			oscDiv_r <= 6'h00;
		end else if (oscTick) begin
			oscDiv_r <= 6'h00;
		end else begin
			oscDiv_r <= oscDiv_r + 6'h01;
		end
	end

	reg  [`SGPD_GS_BITS-1:0]  gsCounter_r;
	wire [`SGPD_GS_BITS:0]    cntSum = {1'b0, gsCounter_r} + 13'h0001;
	wire [`SGPD_GS_BITS-1:0]  cntInc = cntSum[`SGPD_GS_BITS-1:0];

	reg [`SGPD_CHANNELS-1:0] gsNonZero;
	reg [`SGPD_CHANNELS-1:0] gsMatch;

	always @* begin
		gsNonZero = {`SGPD_CHANNELS{1'b0}};
		gsMatch   = {`SGPD_CHANNELS{1'b0}};
		for (i = 0; i < `SGPD_CHANNELS; i = i + 1) begin
			gsNonZero[i] = (grayscaleData_r[i*`SGPD_GS_BITS +: `SGPD_GS_BITS] != `SGPD_GS_ZERO);
			gsMatch[i]   = (grayscaleData_r[i*`SGPD_GS_BITS +: `SGPD_GS_BITS] == cntInc);
		end
	end

	// The match is taken against the next counter value, so a channel stands on for
	// exactly its grayscale value in ticks and a value of FFFh leaves one tick dark.
	reg [2:0]                state_r;
	reg [2:0]                waitCnt_r;
	reg [`SGPD_CHANNELS-1:0] pwmOn_r;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r     <= ST_BLANK;
			waitCnt_r   <= 3'd0;
			gsCounter_r <= `SGPD_GS_ZERO;
			pwmOn_r     <= {`SGPD_CHANNELS{1'b0}};
		end else begin
			case (state_r)
				ST_BLANK: begin
					gsCounter_r <= `SGPD_GS_ZERO;
					pwmOn_r     <= {`SGPD_CHANNELS{1'b0}};
					waitCnt_r   <= 3'd0;
					if (!disS2_r) begin
						state_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					pwmOn_r <= {`SGPD_CHANNELS{1'b0}};
					if (disS2_r) begin
						state_r <= ST_BLANK;
					end else if (oscTick) begin
						if (waitCnt_r == TURNON_CNT - 3'd1) begin
							state_r     <= ST_RUN;
							gsCounter_r <= `SGPD_GS_ZERO;
							// A strobe in the very cycle of turn-on keeps the outputs off.
							pwmOn_r     <= latchRise ? {`SGPD_CHANNELS{1'b0}} : gsNonZero;
						end else begin
							waitCnt_r <= waitCnt_r + 3'd1;
						end
					end
				end
				ST_RUN: begin
					if (disS2_r) begin
						state_r     <= ST_BLANK;
						gsCounter_r <= `SGPD_GS_ZERO;
						pwmOn_r     <= {`SGPD_CHANNELS{1'b0}};
					end else if (oscTick) begin
						gsCounter_r <= cntInc;
						if (gsCounter_r == `SGPD_GS_FULL) begin
							pwmOn_r <= latchRise ? {`SGPD_CHANNELS{1'b0}} : gsNonZero;
						end else if (latchRise) begin
							pwmOn_r <= {`SGPD_CHANNELS{1'b0}};
						end else if (cntInc == `SGPD_GS_FULL) begin
							pwmOn_r <= {`SGPD_CHANNELS{1'b0}};
						end else begin
							pwmOn_r <= pwmOn_r & ~gsMatch;
						end
					end else if (latchRise) begin
						pwmOn_r <= {`SGPD_CHANNELS{1'b0}};
					end
				end
				default: begin
					state_r <= ST_BLANK;
				end
			endcase
		end
	end

	// Delay line for the group stagger; every edge of a channel, on or off, is delayed
	// alike, so the duty of each group is kept while the inrush is spread.
	reg [`SGPD_CHANNELS-1:0] stageHist_r [0:`SGPD_HIST_DEPTH-1];

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (i = 0; i < `SGPD_HIST_DEPTH; i = i + 1) begin
				stageHist_r[i] <= {`SGPD_CHANNELS{1'b0}};
			end
		end else begin
			stageHist_r[0] <= pwmOn_r;
			for (i = 1; i < `SGPD_HIST_DEPTH; i = i + 1) begin
				stageHist_r[i] <= stageHist_r[i-1];
			end
		end
	end

	wire [`SGPD_CHANNELS-1:0] tapGrp1 = stageHist_r[`SGPD_GRP1_CYC-1];
	wire [`SGPD_CHANNELS-1:0] tapGrp2 = stageHist_r[`SGPD_GRP2_CYC-1];
	wire [`SGPD_CHANNELS-1:0] tapGrp3 = stageHist_r[`SGPD_GRP3_CYC-1];

	reg [`SGPD_CHANNELS-1:0] sinkOut_nxt;
	reg [`SGPD_CHANNELS-1:0] sinkOut_r;

	always @* begin
		sinkOut_nxt = {`SGPD_CHANNELS{1'b0}};
		for (i = 0; i < `SGPD_CHANNELS; i = i + 1) begin
			case (i % 4)
				0: sinkOut_nxt[i] = pwmOn_r[i];
				1: sinkOut_nxt[i] = tapGrp1[i];
				2: sinkOut_nxt[i] = tapGrp2[i];
				3: sinkOut_nxt[i] = tapGrp3[i];
				default: sinkOut_nxt[i] = 1'b0;
			endcase
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sinkOut_r <= {`SGPD_CHANNELS{1'b0}};
		end else begin
			sinkOut_r <= sinkOut_nxt;
		end
	end

	assign serialDataOutput  = serialDataOutput_r;
	assign sinkChannelOutput = sinkOut_r;

endmodule // sgpd_core

// ---- tb/sgpd_core_props.sv ----
// Port-level checker of the serial grayscale PWM driver.
`timescale 1ns/1ps
module sgpd_core_props (
	input wire        core_clk,
	input wire        rst,
	input wire        shiftClk,
	input wire        serialDataInput,
	input wire        latchStrobe,
	input wire        outputDisable,
	input wire        serialDataOutput,
	input wire [23:0] sinkChannelOutput
);
	reg  [23:0] prev_r;
	reg  [8:0]  disCnt_r;
	reg  [8:0]  lowCnt_r;
	reg  [19:0] gap_r;
	reg  [17:0] onRun_r;
	reg         seen_r;
	wire [23:0] rise  = sinkChannelOutput & ~prev_r;
	wire        rise0 = |(rise & 24'h111111);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// disCnt_r and lowCnt_r saturate so that a long idle spell never wraps into a false window.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prev_r   <= 24'h000000;
			disCnt_r <= 9'h000;
			lowCnt_r <= 9'h000;
			gap_r    <= 20'h00000;
			onRun_r  <= 18'h00000;
			seen_r   <= 1'b0;
		end else begin
			prev_r   <= sinkChannelOutput;
			disCnt_r <= outputDisable ? disCnt_r + {8'h00, ~&disCnt_r} : 9'h000;
			lowCnt_r <= outputDisable ? 9'h000 : lowCnt_r + {8'h00, ~&lowCnt_r};
			gap_r    <= rise0 ? 20'h00001 : gap_r + 20'h00001;
			onRun_r  <= sinkChannelOutput[0] ? onRun_r + 18'h00001 : 18'h00000;
			seen_r   <= seen_r | rise0;
		end
	end
	chk_disable_off: assert property (disCnt_r > 9'h017 |-> sinkChannelOutput == 24'h000000)
		else $error("output on while disabled");
	chk_strobe_off: assert property ($rose(latchStrobe) |-> ##22 sinkChannelOutput == 24'h000000)
		else $error("output on after latch strobe");
	chk_sdo_fall: assert property ($changed(serialDataOutput) |-> !$past(shiftClk, 2) && $past(shiftClk, 6))
		else $error("serial output moved away from shift clock fall");
	chk_turnon_early: assert property (lowCnt_r > 9'h018 && lowCnt_r < 9'h0C8 |-> sinkChannelOutput == 24'h000000)
		else $error("output on before fifth oscillator edge");
	chk_groups_apart: assert property (rise0 |-> !(|(rise & 24'hEEEEEE)))
		else $error("groups turned on together");
	chk_tick_aligned: assert property (rise0 && seen_r |-> gap_r % 20'h00032 == 20'h00000)
		else $error("turn-on off the oscillator grid");
	chk_on_bound: assert property (onRun_r <= 18'h31FCE)
		else $error("channel on past full count");
	chk_reset_quiet: assert property ($fell(rst) |-> (sinkChannelOutput == 24'h000000) [*8])
		else $error("output on after reset");
	cover property (rise0 && seen_r);
endmodule // sgpd_core_props

bind sgpd_core sgpd_core_props i_props (
	.core_clk(core_clk), .rst(rst), .shiftClk(shiftClk), .serialDataInput(serialDataInput),
	.latchStrobe(latchStrobe), .outputDisable(outputDisable), .serialDataOutput(serialDataOutput),
	.sinkChannelOutput(sinkChannelOutput)
);

// ---- tb/sgpd_host.sv ----
// Host model that shifts grayscale frames and strobes the latch.
`timescale 1ns/1ps
module sgpd_host (
	output reg         shiftClk,
	output reg         serialDataInput,
	output reg         latchStrobe,
	input  wire        serialDataOutput,
	output reg [287:0] captured
);
	initial begin
		shiftClk = 1'b0;
		serialDataInput = 1'b0;
		latchStrobe = 1'b0;
		captured = 288'h0;
	end
	// The shift clock stands low between frames; data is inverted once its hold has run out.
	task shift(input [287:0] frame);
		integer i;
		begin
			for (i = 287; i >= 0; i = i - 1) begin
				serialDataInput = frame[i];
				#24 shiftClk = 1'b1;
				captured = {captured[286:0], serialDataOutput};
				#16 serialDataInput = ~frame[i];
				#8 shiftClk = 1'b0;
			end
		end
	endtask
	task latch;
		begin
			#30 latchStrobe = 1'b1;
			#30 latchStrobe = 1'b0;
			#100;
		end
	endtask
endmodule // sgpd_host

// ---- tb/tb_serial_grayscale_pwm_driver.sv ----
// Self-checking bench of the serial grayscale PWM driver.
`timescale 1ns/1ps
`include "sgpd_regs.vh"
module tb_serial_grayscale_pwm_driver;
	reg          core_clk;
	reg          rst;
	reg          outputDisable;
	wire         shiftClk;
	wire         serialDataInput;
	wire         latchStrobe;
	wire         serialDataOutput;
	wire [23:0]  sinkChannelOutput;
	wire [287:0] captured;
	reg  [287:0] frameA;
	reg  [287:0] frameB;
	reg  [31:0]  seed;
	integer      errors;
	integer      testsRun;
	integer      c;
	integer      n;
	integer      onCnt [0:23];
	integer      first [0:23];

	sgpd_core i_dut (.core_clk(core_clk), .rst(rst), .shiftClk(shiftClk), .serialDataInput(serialDataInput),
		.latchStrobe(latchStrobe), .outputDisable(outputDisable), .serialDataOutput(serialDataOutput),
		.sinkChannelOutput(sinkChannelOutput));
	sgpd_host i_host (.shiftClk(shiftClk), .serialDataInput(serialDataInput), .latchStrobe(latchStrobe),
		.serialDataOutput(serialDataOutput), .captured(captured));

	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			testsRun = testsRun + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	// Values stay within 1..16, with channel 5 set to 0, so every pulse ends inside one short window.
	task build(output [287:0] f);
		integer k;
		begin
			for (k = 0; k < 24; k = k + 1) begin
				seed = lfsr(seed);
				f[12*k +: 12] = {8'h00, seed[3:0]} + 12'h001;
			end
			f[11:0] = 12'h010;
			f[71:60] = 12'h000;
			f[287:276] = 12'h001;
		end
	endtask
	task measure(input [287:0] f);
		integer k;
		begin
			for (k = 0; k < 24; k = k + 1) begin
				onCnt[k] = 0;
				first[k] = -1;
			end
			outputDisable = 1'b0;
			for (c = 0; c < 1300; c = c + 1) begin
				@(negedge core_clk);
				for (k = 0; k < 24; k = k + 1) begin
					if (sinkChannelOutput[k] === 1'b1) begin
						onCnt[k] = onCnt[k] + 1;
						if (first[k] < 0)
							first[k] = c;
					end
				end
			end
			chk(first[0] > 199 && first[0] < 260, 1);
			for (k = 0; k < 24; k = k + 1)
				chk(onCnt[k], f[12*k +: 12] * `SGPD_OSC_DIV);
			for (k = 1; k < 4; k = k + 1)
				chk(first[k] - first[0], k * `SGPD_GRP1_CYC);
			outputDisable = 1'b1;
			repeat (30) @(negedge core_clk);
			chk(sinkChannelOutput, 24'h000000);
			$display("Test of a display period done");
		end
	endtask
	task end_of_test;
		begin
			$display("Compares %0d, mismatches %0d", testsRun, errors);
			if (errors == 0 && testsRun > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// Three frames and two display windows need about 60 us; the limit leaves ample margin.
	initial begin
		#200000;
		errors = errors + 1;
		end_of_test;
	end
	initial begin
		rst = 1'b1;
		outputDisable = 1'b1;
		errors = 0;
		testsRun = 0;
		seed = 32'h0000A3FE;
		repeat (20) @(negedge core_clk);
		rst = 1'b0;
		chk(sinkChannelOutput, 24'h000000);
		build(frameA);
		build(frameB);
		i_host.shift(frameA);
		i_host.latch;
		i_host.shift(frameB);
		for (n = 0; n < 9; n = n + 1)
			chk(captured[32*n +: 32], frameA[32*n +: 32]);
		i_host.latch;
		$display("Test of cascade output done");
		@(negedge core_clk);
		measure(frameB);
		i_host.shift(frameA);
		@(negedge core_clk);
		outputDisable = 1'b0;
		c = 0;
		while (sinkChannelOutput[0] !== 1'b1 && c < 400) begin
			@(negedge core_clk);
			c = c + 1;
		end
		chk(sinkChannelOutput[0], 1);
		i_host.latch;
		chk(sinkChannelOutput, 24'h000000);
		repeat (500) @(negedge core_clk);
		chk(sinkChannelOutput, 24'h000000);
		outputDisable = 1'b1;
		$display("Test of strobe in mid-period done");
		repeat (30) @(negedge core_clk);
		measure(frameA);
		end_of_test;
	end
endmodule // tb_serial_grayscale_pwm_driver
